// ### rtl/papc_pkg.sv
// constants for the analog and power control register bank
`default_nettype none
package papc_pkg;
    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [13:0] DC_CORR_IDX    = 14'h0410;
    localparam logic [13:0] FILT1_IDX      = 14'h0416;
    localparam logic [13:0] EQ_IDX         = 14'h0418;
    localparam logic [13:0] SUP_OVR_IDX    = 14'h041f;
    localparam logic [13:0] SUP_STAT_IDX   = 14'h0421;
    localparam logic [13:0] DEEP_IDX       = 14'h0428;
    localparam logic [13:0] IDLE_LO_IDX    = 14'h0027;

    // ------------------------------------------------------------
    // values after reset and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] DC_CORR_RST    = 16'h2000;
    localparam logic [15:0] FILT1_RST      = 16'h0870;
    localparam logic [15:0] EQ_RST         = 16'h0000;
    localparam logic [15:0] SUP_OVR_RST    = 16'h0000;
    localparam logic [15:0] DEEP_RST       = 16'h0000;
    localparam logic [15:0] IDLE_LO_RST    = 16'h0000;
    localparam logic [15:0] FULL_MASK      = 16'hffff;
    localparam logic [15:0] DEEP_MASK      = 16'h003f;
    localparam logic [15:0] IDLE_LO_MASK   = 16'h000f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FIXED_DC_BIT   = 14;
    localparam int FILT1_LSB      = 8;
    localparam int EQ_LSB         = 8;
    localparam int CORE_FORCE_BIT = 12;
    localparam int IO_FORCE_LSB   = 10;
    localparam int CORE_STAT_BIT  = 2;
    localparam int IO_STAT_LSB    = 0;
    localparam int IDLE_MSB_BIT   = 5;
    localparam int IDLE_EN_BIT    = 4;
    localparam int DPD_FAST_BIT   = 3;
    localparam int DPD_EN_BIT     = 2;
    localparam logic [1:0] IO_FORCED_3V3 = 2'h3;
    localparam logic [1:0] IO_AUTO       = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ       = 25_000_000;
    localparam longint DPD_FAST_MS  = 50;
    localparam longint DPD_SLOW_MS  = 100;
    localparam int     DPD_FAST_CYC = int'(DPD_FAST_MS * CLK_HZ / 1000);
    localparam int     DPD_SLOW_CYC = int'(DPD_SLOW_MS * CLK_HZ / 1000);
    localparam int     DPD_CNT_W    = 22;

    typedef enum logic [1:0] {PAPC_RUN, PAPC_DEEP, PAPC_EXIT} papc_dpd_e;
endpackage : papc_pkg
`default_nettype wire

// ### rtl/papc_idle_gen.sv
// 100BASE-TX idle test pattern generator: a one followed by N zeros
`timescale 1ns/1ns
`default_nettype none
module papc_idle_gen (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       en_i,
    input  wire logic [4:0] len_i,
    output logic            bit_o
);
    import papc_pkg::*;

    logic [4:0] count_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i || len_i == 5'h00) begin // [R9]
            count_ff <= 5'h00;
            bit_o    <= 1'b0;
        end else if (count_ff == 5'h00) begin // [R8]
            count_ff <= len_i;
            bit_o    <= 1'b1;
        end else begin
            count_ff <= count_ff - 5'h01;
            bit_o    <= 1'b0;
        end
    end
endmodule : papc_idle_gen
`default_nettype wire

// ### rtl/papc_dpd_seq.sv
// deep power-down entry and timed exit sequencer
`timescale 1ns/1ns
`default_nettype none
module papc_dpd_seq #(
    parameter int FAST_CYC = 4,
    parameter int SLOW_CYC = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic enable_i,
    input  wire logic fast_i,
    output logic      deep_o,
    output logic      exit_busy_o
);
    import papc_pkg::*;

    papc_dpd_e              state_ff;
    logic [DPD_CNT_W-1:0]   count_ff;

    // exit length is sampled when the enable drops; a later change of
    // the speed bit does not stretch or cut a running exit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= PAPC_RUN;
            count_ff <= '0;
        end else begin
            unique case (state_ff)
                PAPC_RUN: begin
                    if (enable_i) state_ff <= PAPC_DEEP; // [R12]
                end
                PAPC_DEEP: begin
                    if (!enable_i) begin // [R12]
                        state_ff <= PAPC_EXIT;
                        count_ff <= fast_i ? DPD_CNT_W'(FAST_CYC - 1)
                                           : DPD_CNT_W'(SLOW_CYC - 1); // [R11]
                    end
                end
                PAPC_EXIT: begin
                    if (enable_i) state_ff <= PAPC_DEEP;
                    else if (count_ff == '0) state_ff <= PAPC_RUN;
                    else count_ff <= count_ff - 1'b1;
                end
                default: state_ff <= PAPC_RUN;
            endcase
        end
    end

    assign deep_o      = (state_ff == PAPC_DEEP);
    assign exit_busy_o = (state_ff == PAPC_EXIT);
endmodule : papc_dpd_seq
`default_nettype wire

// ### rtl/papc_regs.sv
// analog, supply-detect and deep power-down register bank on wishbone
//
// Summary of operation
// [R1] bit 14 selects fixed DC correction
// [R2] bits 12:8 drive filter one cut-off
// [R3] bits 13:8 drive analog equalizer control
// [R4] core force bit makes core supply 3.3V
// [R5] io override 11 forces 3.3V, 00 auto
// [R6] status reports core bit2, io bits1:0
// [R7] software may override supply detection levels
// [R8] idle length: msb here, low four elsewhere
// [R9] zero length clears shifter, ones give 31
// [R10] bit 4 enables idle test pattern
// [R11] bit 3 picks 50ms or 100ms exit
// [R12] bit 2 enters and leaves deep power-down
// [R13] software enables standard power-down beforehand
`timescale 1ns/1ns
`default_nettype none
module papc_regs
    import papc_pkg::*;
#(
    parameter int FAST_CYC = papc_pkg::DPD_FAST_CYC,
    parameter int SLOW_CYC = papc_pkg::DPD_SLOW_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // raw detector levels from the analog supply monitors
    input  wire logic        core_supply_det_i,
    input  wire logic [1:0]  io_supply_det_i,
    // controls toward analog and transmit logic
    output logic             fixed_dc_corr_o,
    output logic [4:0]       filter1_cutoff_o,
    output logic [5:0]       eq_ctrl_o,
    output logic             analog_core_supply_o,
    output logic [1:0]       io_supply_level_o,
    output logic             idle_test_en_o,
    output logic             idle_test_bit_o,
    output logic             deep_sleep_control_o,
    output logic             dpd_exit_busy_o
);
    import papc_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // merge a 16-bit write through the two low byte lanes and a mask
    function automatic logic [15:0] wr_merge(
        input logic [15:0] old_v,
        input logic [31:0] dat,
        input logic [3:0]  sel,
        input logic [15:0] mask
    );
        logic [15:0] lanes;
        lanes   = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        wr_merge = (dat[15:0] & lanes) | (old_v & ~lanes);
    endfunction : wr_merge

    function automatic logic [31:0] rd_word(input logic [15:0] v);
        rd_word = {16'h0000, v};
    endfunction : rd_word

    // true when the decoded word index names the given register
    function automatic logic reg_hit(input logic [13:0] at, input logic [13:0] reg_idx);
        reg_hit = (at == reg_idx);
    endfunction : reg_hit

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [13:0] idx;
    logic        req;
    logic        wr_go;
    logic        ack_ff;

    assign idx   = wb_adr_i[15:2];
    assign req   = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_go = req && wb_we_i;

    // one wait state: ack in the cycle after the request is seen, and
    // dropped after a single cycle so back-to-back requests stay apart
    always_ff @(posedge clk_i) begin
        if (rst_i) ack_ff <= 1'b0;
        else       ack_ff <= req;
    end

    assign wb_ack_o = ack_ff;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [15:0] dc_corr_ff;
    logic [15:0] filt1_ff;
    logic [15:0] eq_ff;
    logic [15:0] sup_ovr_ff;
    logic [15:0] deep_ff;
    logic [15:0] idle_lo_ff;

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    // each strobe is high only at the edge that takes the write, so a
    // request held through its ack cycle cannot write twice
    logic wr_dc_corr;
    logic wr_filt1;
    logic wr_eq;
    logic wr_sup_ovr;
    logic wr_deep;
    logic wr_idle_lo;

    assign wr_dc_corr = wr_go && reg_hit(idx, DC_CORR_IDX);
    assign wr_filt1   = wr_go && reg_hit(idx, FILT1_IDX);
    assign wr_eq      = wr_go && reg_hit(idx, EQ_IDX);
    assign wr_sup_ovr = wr_go && reg_hit(idx, SUP_OVR_IDX); // [R7]
    assign wr_deep    = wr_go && reg_hit(idx, DEEP_IDX);
    assign wr_idle_lo = wr_go && reg_hit(idx, IDLE_LO_IDX); // [R8]

    // ------------------------------------------------------------
    // next register values
    // ------------------------------------------------------------
    // bits 15:6 of the deep power-down word are read-only zero and the
    // idle length word keeps only its low four bits; the masks hold them
    logic [15:0] nxt_dc_corr;
    logic [15:0] nxt_filt1;
    logic [15:0] nxt_eq;
    logic [15:0] nxt_sup_ovr;
    logic [15:0] nxt_deep;
    logic [15:0] nxt_idle_lo;

    always_comb begin
        nxt_dc_corr = wr_dc_corr ? wr_merge(dc_corr_ff, wb_dat_i, wb_sel_i, FULL_MASK) : dc_corr_ff;
        nxt_filt1   = wr_filt1 ? wr_merge(filt1_ff, wb_dat_i, wb_sel_i, FULL_MASK) : filt1_ff;
        nxt_eq      = wr_eq ? wr_merge(eq_ff, wb_dat_i, wb_sel_i, FULL_MASK) : eq_ff;
        nxt_sup_ovr = wr_sup_ovr ? wr_merge(sup_ovr_ff, wb_dat_i, wb_sel_i, FULL_MASK) : sup_ovr_ff;
        nxt_deep    = wr_deep ? wr_merge(deep_ff, wb_dat_i, wb_sel_i, DEEP_MASK) : deep_ff;
        nxt_idle_lo = wr_idle_lo ? wr_merge(idle_lo_ff, wb_dat_i, wb_sel_i, IDLE_LO_MASK) : idle_lo_ff;
    end

    // each word returns to its power-up value on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) dc_corr_ff <= DC_CORR_RST;
        else       dc_corr_ff <= nxt_dc_corr;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) filt1_ff <= FILT1_RST;
        else       filt1_ff <= nxt_filt1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) eq_ff <= EQ_RST;
        else       eq_ff <= nxt_eq;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) sup_ovr_ff <= SUP_OVR_RST;
        else       sup_ovr_ff <= nxt_sup_ovr;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) deep_ff <= DEEP_RST;
        else       deep_ff <= nxt_deep;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) idle_lo_ff <= IDLE_LO_RST;
        else       idle_lo_ff <= nxt_idle_lo;
    end

    // ------------------------------------------------------------
    // analog control outputs
    // ------------------------------------------------------------
    assign fixed_dc_corr_o  = dc_corr_ff[FIXED_DC_BIT]; // [R1]
    assign filter1_cutoff_o = filt1_ff[FILT1_LSB +: 5]; // [R2]
    assign eq_ctrl_o        = eq_ff[EQ_LSB +: 6]; // [R3]

    // ------------------------------------------------------------
    // supply detection
    // ------------------------------------------------------------
    // detector levels come from the analog domain and are synchronised
    // the two io bits may settle a cycle apart; a mixed code lasts one
    // cycle and is harmless since the levels only move at power-up
    logic       core_meta_ff;
    logic       core_sync_ff;
    logic [1:0] io_meta_ff;
    logic [1:0] io_sync_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_meta_ff <= 1'b0;
            core_sync_ff <= 1'b0;
            io_meta_ff   <= 2'h0;
            io_sync_ff   <= 2'h0;
        end else begin
            core_meta_ff <= core_supply_det_i;
            core_sync_ff <= core_meta_ff;
            io_meta_ff   <= io_supply_det_i;
            io_sync_ff   <= io_meta_ff;
        end
    end

    logic       nxt_core_lvl;
    logic [1:0] nxt_io_lvl;
    logic       core_lvl_ff;
    logic [1:0] io_lvl_ff;

    // override codes 01 and 10 are undefined; they fall back to the
    // detector rather than inventing a level
    always_comb begin
        nxt_core_lvl = sup_ovr_ff[CORE_FORCE_BIT] ? 1'b1 : core_sync_ff; // [R4]
        if (sup_ovr_ff[IO_FORCE_LSB +: 2] == IO_FORCED_3V3)
            nxt_io_lvl = IO_FORCED_3V3; // [R5]
        else
            nxt_io_lvl = io_sync_ff; // [R5]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_lvl_ff <= 1'b0;
            io_lvl_ff   <= 2'h0;
        end else begin
            core_lvl_ff <= nxt_core_lvl;
            io_lvl_ff   <= nxt_io_lvl;
        end
    end

    // levels come from flops so the analog side never sees a glitch
    // from the override mux
    assign analog_core_supply_o = core_lvl_ff;
    assign io_supply_level_o    = io_lvl_ff;

    // status shows the effective levels, not the raw detector, so
    // software reads back what an override did
    logic [15:0] sup_stat;
    always_comb begin
        sup_stat                    = 16'h0000;
        sup_stat[CORE_STAT_BIT]     = core_lvl_ff; // [R6]
        sup_stat[IO_STAT_LSB +: 2]  = io_lvl_ff; // [R6]
    end

    // ------------------------------------------------------------
    // idle test pattern
    // ------------------------------------------------------------
    // a zero length holds the serial bit low instead of sending ones
    // back to back
    logic [4:0] idle_len;
    assign idle_len       = {deep_ff[IDLE_MSB_BIT], idle_lo_ff[3:0]}; // [R8]
    assign idle_test_en_o = deep_ff[IDLE_EN_BIT]; // [R10]

    papc_idle_gen u_idle (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .en_i  (deep_ff[IDLE_EN_BIT]),
        .len_i (idle_len),
        .bit_o (idle_test_bit_o)
    );

    // ------------------------------------------------------------
    // deep power-down
    // ------------------------------------------------------------
    // the standard power-down that must precede entry lives outside
    // this bank; entry here trusts software to have done it
    papc_dpd_seq #(
        .FAST_CYC (FAST_CYC),
        .SLOW_CYC (SLOW_CYC)
    ) u_dpd (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .enable_i    (deep_ff[DPD_EN_BIT]),
        .fast_i      (deep_ff[DPD_FAST_BIT]),
        .deep_o      (deep_sleep_control_o),
        .exit_busy_o (dpd_exit_busy_o)
    ); // [R12] [R13]

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // unmapped words ack normally and read zero, so a stray probe
    // never stalls the bus
    logic [31:0] nxt_rdata;
    always_comb begin
        unique case (idx)
            DC_CORR_IDX:  nxt_rdata = rd_word(dc_corr_ff);
            FILT1_IDX:    nxt_rdata = rd_word(filt1_ff);
            EQ_IDX:       nxt_rdata = rd_word(eq_ff);
            SUP_OVR_IDX:  nxt_rdata = rd_word(sup_ovr_ff);
            SUP_STAT_IDX: nxt_rdata = rd_word(sup_stat);
            DEEP_IDX:     nxt_rdata = rd_word(deep_ff);
            IDLE_LO_IDX:  nxt_rdata = rd_word(idle_lo_ff);
            default:      nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)                 wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_we_i)  wb_dat_o <= nxt_rdata;
    end
endmodule : papc_regs
`default_nettype wire

// ### bench/papc_assertions.sv
// checker for the analog and power control register bank
`timescale 1ns/1ns
`default_nettype none
module papc_assertions
    import papc_pkg::*;
#(
    parameter int FAST_CYC = 5,
    parameter int SLOW_CYC = 10
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        fixed_dc_corr_o,
    input  wire logic [4:0]  filter1_cutoff_o,
    input  wire logic [5:0]  eq_ctrl_o,
    input  wire logic        analog_core_supply_o,
    input  wire logic [1:0]  io_supply_level_o,
    input  wire logic        idle_test_en_o,
    input  wire logic        idle_test_bit_o,
    input  wire logic        deep_sleep_control_o,
    input  wire logic        dpd_exit_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic        req;
    logic        fast_ff;
    logic [31:0] busy_cnt_ff;
    logic [4:0]  len_ff;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // exit length is judged against the last speed bit software wrote
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_ff     <= 1'b0;
            busy_cnt_ff <= 32'h0;
            len_ff      <= 5'h00;
        end else begin
            if (req && wb_we_i && wb_adr_i[15:2] == DEEP_IDX && wb_sel_i[0]) fast_ff <= wb_dat_i[DPD_FAST_BIT];
            if (req && wb_we_i && wb_adr_i[15:2] == DEEP_IDX && wb_sel_i[0]) len_ff[4] <= wb_dat_i[IDLE_MSB_BIT];
            if (req && wb_we_i && wb_adr_i[15:2] == IDLE_LO_IDX && wb_sel_i[0]) len_ff[3:0] <= wb_dat_i[3:0];
            busy_cnt_ff <= dpd_exit_busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
        end
    end
    sequence s_wr(idx, lane);
        req && wb_we_i && wb_adr_i[15:2] == idx && wb_sel_i[lane];
    endsequence
    property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack is not a single pulse");
    property p_fixed_dc; s_wr(DC_CORR_IDX, 1) |-> ##2 fixed_dc_corr_o == $past(wb_dat_i[14], 2); endproperty
    a_fixed_dc: assert property (p_fixed_dc) else $error("fixed dc select wrong");
    property p_filter; s_wr(FILT1_IDX, 1) |-> ##2 filter1_cutoff_o == $past(wb_dat_i[12:8], 2); endproperty
    a_filter: assert property (p_filter) else $error("filter cut-off wrong");
    property p_eq; s_wr(EQ_IDX, 1) |-> ##2 eq_ctrl_o == $past(wb_dat_i[13:8], 2); endproperty
    a_eq: assert property (p_eq) else $error("equalizer control wrong");
    property p_core; s_wr(SUP_OVR_IDX, 1) ##0 wb_dat_i[12] |-> ##2 analog_core_supply_o; endproperty
    a_core: assert property (p_core) else $error("core supply not forced");
    property p_io; s_wr(SUP_OVR_IDX, 1) ##0 wb_dat_i[11:10] == 2'h3 |-> ##2 io_supply_level_o == 2'h3; endproperty
    a_io: assert property (p_io) else $error("io supply not forced");
    property p_status;
        req && !wb_we_i && wb_adr_i[15:2] == SUP_STAT_IDX |=>
            wb_dat_o == {29'h0, $past(analog_core_supply_o), $past(io_supply_level_o)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_idle_en; s_wr(DEEP_IDX, 0) |-> ##2 idle_test_en_o == $past(wb_dat_i[4], 2); endproperty
    a_idle_en: assert property (p_idle_en) else $error("idle enable wrong");
    property p_deep_on; s_wr(DEEP_IDX, 0) ##0 wb_dat_i[2] |-> ##[1:3] deep_sleep_control_o; endproperty
    a_deep_on: assert property (p_deep_on) else $error("deep power-down not entered");
    // an exit cut short by a new entry is not a full exit
    property p_exit_len;
        $fell(dpd_exit_busy_o) && !deep_sleep_control_o |-> busy_cnt_ff == (fast_ff ? FAST_CYC : SLOW_CYC);
    endproperty
    a_exit_len: assert property (p_exit_len) else $error("exit duration wrong");
    property p_idle_zero; idle_test_en_o && len_ff == 5'h00 |=> !idle_test_bit_o; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle bit sent with zero length");
endmodule : papc_assertions
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the analog and power control register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
    import papc_pkg::*;
    typedef struct {logic w; logic [15:0] a; logic [15:0] d; logic [3:0] s; logic [31:0] e;} papc_row_s;
    localparam int FAST = 5;
    localparam int SLOW = 10;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        core_det = 1'b0;
    logic [1:0]  io_det = 2'h1;
    logic [15:0] adr = 16'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, fixed_dc_corr_o, analog_core_supply_o, idle_test_en_o, idle_test_bit_o;
    wire logic deep_sleep_control_o, dpd_exit_busy_o;
    wire logic [4:0] filter1_cutoff_o;
    wire logic [5:0] eq_ctrl_o;
    wire logic [1:0] io_supply_level_o;
    int mismatches = 0;
    int tests_run = 0;
    int n;
    papc_row_s rows [18] = '{
        '{0, 16'h1040, 0, 3, 32'h2000}, '{0, 16'h1058, 0, 3, 32'h0870}, '{0, 16'h1060, 0, 3, 32'h0},
        '{0, 16'h107c, 0, 3, 32'h0}, '{0, 16'h10a0, 0, 3, 32'h0}, '{0, 16'h009c, 0, 3, 32'h0},
        '{1, 16'h1040, 16'hffff, 3, 0}, '{0, 16'h1040, 0, 3, 32'hffff}, '{1, 16'h1058, 16'h1f00, 2, 0},
        '{0, 16'h1058, 0, 3, 32'h1f70}, '{1, 16'h1060, 16'h3f00, 3, 0}, '{0, 16'h1060, 0, 3, 32'h3f00},
        '{1, 16'h10a0, 16'hfffb, 3, 0}, '{0, 16'h10a0, 0, 3, 32'h003b}, '{1, 16'h009c, 16'hffff, 3, 0},
        '{0, 16'h009c, 0, 3, 32'h000f}, '{1, 16'h2000, 16'hffff, 3, 0}, '{0, 16'h2000, 0, 3, 32'h0}};
    always #20 clk_i = ~clk_i;
    papc_regs #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
        .core_supply_det_i(core_det), .io_supply_det_i(io_det), .fixed_dc_corr_o, .filter1_cutoff_o,
        .eq_ctrl_o, .analog_core_supply_o, .io_supply_level_o, .idle_test_en_o, .idle_test_bit_o,
        .deep_sleep_control_o, .dpd_exit_busy_o);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // no limit of its own on the ack wait: only the watchdog ends a hung transfer
    task automatic wb(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= s;
        dat <= {16'h0, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
        wb(1'b0, a, 16'h0, 4'h3);
        chk(rd, e);
    endtask : rdchk
    // one period of the idle pattern is a one plus len zeros
    task automatic period(input int exp);
        int k;
        k = 0;
        repeat (40) @(posedge clk_i);
        while (idle_test_bit_o !== 1'b1 && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (idle_test_bit_o !== 1'b1 && k < 100);
        chk(32'(k), 32'(exp));
    endtask : period
    task automatic dpd(input logic [15:0] ctl, input int exp);
        int k;
        k = 0;
        wb(1'b1, 16'h10a0, ctl | 16'h0004, 4'h1);
        repeat (4) @(posedge clk_i);
        chk(32'(deep_sleep_control_o), 32'h1);
        wb(1'b1, 16'h10a0, ctl, 4'h1);
        while (dpd_exit_busy_o !== 1'b1 && k < 10) begin
            @(posedge clk_i);
            k++;
        end
        k = 0;
        while (dpd_exit_busy_o === 1'b1 && k < 1000) begin
            k++;
            @(posedge clk_i);
        end
        chk(32'(k), 32'(exp));
        chk(32'(deep_sleep_control_o), 32'h0);
    endtask : dpd
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        #400000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
            if (!rows[i].w) chk(rd, rows[i].e);
        end
        chk(32'(fixed_dc_corr_o), 32'h1);
        chk(32'(filter1_cutoff_o), 32'h1f);
        chk(32'(eq_ctrl_o), 32'h3f);
        chk(32'(idle_test_en_o), 32'h1);
        $display("register table done");
        period(32);
        wb(1'b1, 16'h009c, 16'h0001, 4'h1);
        wb(1'b1, 16'h10a0, 16'h0018, 4'h1);
        period(2);
        wb(1'b1, 16'h009c, 16'h0000, 4'h1);
        wb(1'b1, 16'h10a0, 16'h0038, 4'h1);
        period(17);
        wb(1'b1, 16'h10a0, 16'h0018, 4'h1);
        repeat (4) @(posedge clk_i);
        n = 0;
        repeat (40) begin
            @(posedge clk_i);
            if (idle_test_bit_o !== 1'b0) n++;
        end
        chk(32'(n), 32'h0);
        $display("idle pattern done");
        rdchk(16'h1084, 32'h1);
        wb(1'b1, 16'h107c, 16'h1c00, 4'h2);
        rdchk(16'h1084, 32'h7);
        chk(32'({analog_core_supply_o, io_supply_level_o}), 32'h7);
        wb(1'b1, 16'h107c, 16'h0800, 4'h2);
        rdchk(16'h1084, 32'h1);
        core_det <= 1'b1;
        io_det   <= 2'h0;
        repeat (6) @(posedge clk_i);
        rdchk(16'h1084, 32'h4);
        wb(1'b1, 16'h1084, 16'hffff, 4'h3);
        rdchk(16'h1084, 32'h4);
        $display("supply detect done");
        // standard power-down sits outside this bank; the bench plays software that set it first
        dpd(16'h0000, SLOW);
        dpd(16'h0008, FAST);
        $display("deep power-down done");
        wb(1'b1, 16'h10a0, 16'h0014, 4'h1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(32'(filter1_cutoff_o), 32'h8);
        chk(32'({idle_test_en_o, deep_sleep_control_o, dpd_exit_busy_o}), 32'h0);
        rdchk(16'h1058, 32'h0870);
        rdchk(16'h10a0, 32'h0);
        $display("second reset done");
        complete_run();
    end
endmodule : tb
bind papc_regs papc_assertions #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) chk_u (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fixed_dc_corr_o, .filter1_cutoff_o,
    .eq_ctrl_o, .analog_core_supply_o, .io_supply_level_o, .idle_test_en_o, .idle_test_bit_o,
    .deep_sleep_control_o, .dpd_exit_busy_o);
`default_nettype wire
